// ### shared/mdcu_pkg.sv
package mdcu_pkg;
    // Register address and layout
    localparam logic [31:0] CFG_ADDR = 32'he0042004;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [31:0] CFG_WMASK = 32'h000000e7;
    localparam int SLEEP_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int STANDBY_BIT = 2;
    localparam int TRACE_EN_BIT = 5;
    localparam int TRACE_MODE_LO = 6;
    // Transfer size code for a word access
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // Trace modes
    localparam logic [1:0] TMODE_ASYNC = 2'h0;
    localparam logic [1:0] TMODE_SYNC1 = 2'h1;
    localparam logic [1:0] TMODE_SYNC2 = 2'h2;
    localparam logic [1:0] TMODE_SYNC4 = 2'h3;
    // Freeze selector width
    localparam int FRZ_W = 8;

    // Four-state base so the mode can travel on a port net
    typedef enum logic [1:0] {
        MDCU_RUN,
        MDCU_SLEEP,
        MDCU_STOP,
        MDCU_STANDBY
    } mdcu_pmode_t;

    // Clock and power steering outputs
    typedef struct packed {
        logic core_clk_on;
        logic bus_clk_on;
        logic bus_from_core_src;
        logic clk_from_rc_osc;
        logic digital_powered;
        logic standby_sys_reset;
        logic restore_reset_clocks;
    } mdcu_clkctl_t;

    // Trace pin assignment
    typedef struct packed {
        logic swo_assigned;
        logic clk_assigned;
        logic [3:0] lanes_assigned;
    } mdcu_trace_t;
endpackage : mdcu_pkg

// ### testbench/mdcu_chk_asserts.sv
`timescale 1ns/1ps
module mdcu_chk (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Bus
    input wire logic PPB_SEL,
    input wire logic PPB_WRITE,
    input wire logic [31:0] PPB_ADDR,
    input wire logic [1:0] PPB_SIZE,
    input wire logic [31:0] PPB_WDATA,
    input wire logic PPB_READY,
    input wire logic PPB_ERROR,
    // Levels
    input wire logic DEBUG_SESSION,
    input wire logic DEBUG_SLEEP_KEEP_BUS_CLOCK,
    input wire logic TRACE_IO_ENABLE,
    input wire logic [1:0] TRACE_MODE_SEL,
    input wire mdcu_pkg::mdcu_clkctl_t CLK_CTL,
    input wire mdcu_pkg::mdcu_trace_t TRACE_PINS,
    input wire logic SYSTICK_RUN
);
    // All checks on the rising edge, off in power-on reset
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);
    // Bus answer
    a_ready_next: assert property (PPB_SEL |=> PPB_READY)
        else $error("no ready");
    a_addr_err: assert property (
        PPB_SEL && PPB_ADDR != mdcu_pkg::CFG_ADDR |=> PPB_ERROR) else $error("bad address");
    a_size_err: assert property (
        PPB_SEL && PPB_SIZE != mdcu_pkg::SIZE_WORD |=> PPB_ERROR) else $error("bad size");
    // Levels follow a good write
    a_write_level: assert property (
        PPB_SEL && PPB_WRITE && PPB_ADDR == mdcu_pkg::CFG_ADDR && PPB_SIZE == 2'h2
        |=> DEBUG_SLEEP_KEEP_BUS_CLOCK == $past(PPB_WDATA[0])
        && TRACE_IO_ENABLE == $past(PPB_WDATA[5])) else $error("level stale");
    // Trace pins
    a_trace_off: assert property (!TRACE_IO_ENABLE |=> TRACE_PINS == 6'h0)
        else $error("pins assigned");
    a_sync4_lanes: assert property (
        TRACE_IO_ENABLE && TRACE_MODE_SEL == 2'h3
        |=> TRACE_PINS.clk_assigned && TRACE_PINS.lanes_assigned == 4'hf) else $error("lanes");
    // Clocks and tick
    a_session_clks: assert property (
        DEBUG_SESSION [*4] |-> CLK_CTL.core_clk_on && CLK_CTL.bus_clk_on) else $error("clk off");
    a_systick_on: assert property (SYSTICK_RUN)
        else $error("tick stopped");
endmodule : mdcu_chk

bind mdcu_top mdcu_chk chk_u (.*);

// ### testbench/mdcu_host.sv
`timescale 1ns/1ps
module mdcu_host (
    // Clock
    input wire logic clk,
    // Request
    output logic sel,
    output logic wr,
    output logic [31:0] addr,
    output logic [1:0] size,
    output logic [31:0] wdata,
    // Answer
    input wire logic [31:0] rdata,
    input wire logic ready,
    input wire logic err
);
    // Bus idle at time zero
    initial begin
        {sel, wr, addr, size, wdata} = {2'h0, 32'h0, 2'h2, 32'h0};
    end
    // One-cycle request, answer taken in the next cycle
    task xfer(input logic w, input logic [31:0] a, input logic [1:0] s,
        input logic [31:0] d, output logic [31:0] q, output logic e, output logic ok);
        @(posedge clk);
        #1;
        {sel, wr, addr, size} = {1'b1, w, a, s};
        wdata = (a == mdcu_pkg::CFG_ADDR) ? (d & mdcu_pkg::CFG_WMASK) : d;
        @(posedge clk);
        #1;
        {ok, q, e} = {ready, rdata, err};
        // Released lines toggle so stale values never look live
        {sel, addr, wdata} = {1'b0, ~addr, ~wdata};
    endtask : xfer
endmodule : mdcu_host

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] A = mdcu_pkg::CFG_ADDR;
    localparam logic [1:0] W = mdcu_pkg::SIZE_WORD;
    logic clk, rstn, srst_n, halt, sess, lp_sl, lp_st, lp_sb, sel, wr, rdy, err, e, ok;
    logic k_sl, k_st, k_sb, t_en, tick;
    logic [1:0] size, tmode;
    logic [31:0] addr, wd, rdat, q;
    logic [7:0] frz, frz_act;
    mdcu_pkg::mdcu_clkctl_t ctl;
    mdcu_pkg::mdcu_trace_t pins;
    // Expected steering per low-power case and the bits it fixes
    logic [6:0] ex [6] = '{7'h44, 7'h70, 7'h01, 7'h69, 7'h00, 7'h6e};
    logic [6:0] mk [6] = '{7'h64, 7'h70, 7'h61, 7'h69, 7'h64, 7'h6e};
    logic [5:0] tp [4] = '{6'h20, 6'h11, 6'h13, 6'h1f};
    int failures = 0;
    int num_checks = 0;
    // Design and host
    mdcu_top dut_u (.SYS_CLK(clk), .RSTN(rstn), .SYS_RSTN(srst_n), .PPB_SEL(sel),
        .PPB_WRITE(wr), .PPB_ADDR(addr), .PPB_SIZE(size), .PPB_WDATA(wd), .PPB_RDATA(rdat),
        .PPB_READY(rdy), .PPB_ERROR(err), .CORE_HALTED(halt), .DEBUG_SESSION(sess),
        .LP_SLEEP(lp_sl), .LP_STOP(lp_st), .LP_STANDBY(lp_sb), .FREEZE_SELECT(frz),
        .DEBUG_SLEEP_KEEP_BUS_CLOCK(k_sl), .DEBUG_STOP_KEEP_CLOCKS(k_st),
        .DEBUG_STANDBY_KEEP_CLOCKS(k_sb), .TRACE_IO_ENABLE(t_en), .TRACE_MODE_SEL(tmode),
        .CLK_CTL(ctl), .TRACE_PINS(pins), .FREEZE_ACTIVE(frz_act), .SYSTICK_RUN(tick));
    mdcu_host host_u (.clk(clk), .sel(sel), .wr(wr), .addr(addr), .size(size),
        .wdata(wd), .rdata(rdat), .ready(rdy), .err(err));
    // Masked compare
    task check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    // Transfer with answer and error flag compared
    task acc(input logic w, input logic [31:0] a, input logic [1:0] s,
        input logic [31:0] d, input logic xe);
        host_u.xfer(w, a, s, d, q, e, ok);
        check({30'h0, ok, e}, {30'h0, 1'b1, xe}, 32'h3);
    endtask : acc
    // Steering compare for one low-power case, limited to some bits
    task ctl_cmp(input int i, input logic [6:0] m);
        check({25'h0, ctl}, {25'h0, ex[i]}, {25'h0, mk[i] & m});
    endtask : ctl_cmp
    // Register read
    task rd_cfg(input logic [31:0] x);
        acc(1'b0, A, W, 32'h0, 1'b0);
        check(q, x, 32'hffffffff);
    endtask : rd_cfg
    // Let synchronisers and output stages settle
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    // Verdict
    task results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    initial begin
        #20000;
        failures++;
        results();
    end
    // Tests
    initial begin
        {rstn, srst_n, halt, sess, lp_sl, lp_st, lp_sb, frz} = {7'h20, 8'h0};
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        rd_cfg(32'h0);
        srst_n = 1'b0;
        acc(1'b1, A, W, 32'hffffffff, 1'b0);
        srst_n = 1'b1;
        rd_cfg(32'he7);
        check({26'h0, k_sb, k_st, k_sl, t_en, tmode}, 32'h3f, 32'h3f);
        acc(1'b1, A + 32'h4, W, 32'h0, 1'b1);
        acc(1'b1, A, 2'h1, 32'h0, 1'b1);
        rd_cfg(32'he7);
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, A, W, {24'h0, m[1:0], 6'h20}, 1'b0);
            settle();
            check({26'h0, pins}, {26'h0, tp[m]}, 32'h3f);
        end
        acc(1'b1, A, W, 32'hc0, 1'b0);
        settle();
        check({26'h0, pins}, 32'h0, 32'h3f);
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, A, W, (i % 2) ? (32'h1 << (i / 2)) : 32'h0, 1'b0);
            {lp_sl, lp_st, lp_sb} = 3'h4 >> (i / 2);
            settle();
            ctl_cmp(i, 7'h70);
            ctl_cmp(i, 7'h0f);
            {lp_sl, lp_st, lp_sb} = 3'h0;
            settle();
        end
        {sess, halt, lp_st, frz} = {3'h7, 8'ha5};
        settle();
        check({25'h0, ctl}, 32'h60, 32'h60);
        check({31'h0, tick}, 32'h1, 32'h1);
        check({24'h0, frz_act}, 32'ha5, 32'hff);
        halt = 1'b0;
        settle();
        check({24'h0, frz_act}, 32'h0, 32'hff);
        rstn = 1'b0;
        @(posedge clk);
        #1;
        rstn = 1'b1;
        rd_cfg(32'h0);
        results();
    end
endmodule : tb

// ### verilog/mdcu_clk_steer.sv
`timescale 1ns/1ps
module mdcu_clk_steer (
    // Configuration
    input wire logic keep_sleep,
    input wire logic keep_stop,
    input wire logic keep_standby,
    input wire logic debug_active,
    // Low-power mode
    input mdcu_pkg::mdcu_pmode_t pmode,
    // Steering
    output mdcu_pkg::mdcu_clkctl_t ctl
);
    // Per-mode clock and power decisions
    always_comb begin
        ctl = '0;
        ctl.core_clk_on = 1'b1;
        ctl.bus_clk_on = 1'b1;
        ctl.digital_powered = 1'b1;
        case (pmode)
            mdcu_pkg::MDCU_SLEEP: begin
                ctl.bus_clk_on = keep_sleep | debug_active; // [RULE_14] [RULE_17]
                ctl.bus_from_core_src = keep_sleep; // [RULE_15]
            end
            mdcu_pkg::MDCU_STOP: begin
                ctl.core_clk_on = keep_stop | debug_active; // [RULE_11] [RULE_17]
                ctl.bus_clk_on = keep_stop | debug_active;
                ctl.clk_from_rc_osc = keep_stop; // [RULE_12]
                ctl.restore_reset_clocks = 1'b1;
            end
            mdcu_pkg::MDCU_STANDBY: begin
                ctl.core_clk_on = keep_standby | debug_active; // [RULE_09] [RULE_17]
                ctl.bus_clk_on = keep_standby | debug_active;
                ctl.digital_powered = keep_standby | debug_active;
                ctl.clk_from_rc_osc = keep_standby; // [RULE_10]
                ctl.standby_sys_reset = keep_standby;
            end
            default: begin
            end
        endcase
    end
endmodule : mdcu_clk_steer

// ### verilog/mdcu_top.sv
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) Register decoded at its fixed bus address
// (RULE_02) Only word accesses are honoured
// (RULE_03) Power-on reset alone clears the register
// (RULE_04) Writes accepted while system reset held
// (RULE_05) Application software may write it too
// (RULE_06) Writers keep reserved bits zero
// (RULE_07) Trace disabled leaves trace pins unassigned
// (RULE_08) Trace mode selects async or 1/2/4 lanes
// (RULE_09) Standby clear: clocks off, power removed
// (RULE_10) Standby set: powered, RC clocks, reset
// (RULE_11) Stop clear: all clocks stop, reset clocks
// (RULE_12) Stop set: RC oscillator drives both clocks
// (RULE_13) Software reprograms PLL and crystal after stop
// (RULE_14) Sleep clear: core runs, bus clock gated
// (RULE_15) Sleep set: bus clock follows core clock
// (RULE_16) System tick never frozen in debug modes
// (RULE_17) Clocks stay on during a debug session
// (RULE_18) Host sets debug bits before low power
// (RULE_19) Timers and watchdogs selectably freeze at halt
// (RULE_20) CAN receive and SMBus timeout selectably freeze
// (RULE_21) Config bits are level outputs after write
module mdcu_top (
    // Clock and power-on reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // System reset level, does not touch the register
    input wire logic SYS_RSTN,
    // Private peripheral bus slave
    input wire logic PPB_SEL,
    input wire logic PPB_WRITE,
    input wire logic [31:0] PPB_ADDR,
    input wire logic [1:0] PPB_SIZE,
    input wire logic [31:0] PPB_WDATA,
    output logic [31:0] PPB_RDATA,
    output logic PPB_READY,
    output logic PPB_ERROR,
    // Core and power state
    input wire logic CORE_HALTED,
    input wire logic DEBUG_SESSION,
    input wire logic LP_SLEEP,
    input wire logic LP_STOP,
    input wire logic LP_STANDBY,
    // Freeze selection for timers, watchdogs, CAN, SMBus
    input wire logic [7:0] FREEZE_SELECT,
    // Configuration levels
    output logic DEBUG_SLEEP_KEEP_BUS_CLOCK,
    output logic DEBUG_STOP_KEEP_CLOCKS,
    output logic DEBUG_STANDBY_KEEP_CLOCKS,
    output logic TRACE_IO_ENABLE,
    output logic [1:0] TRACE_MODE_SEL,
    // Steering to clock controller, power controller, pin mux
    output mdcu_pkg::mdcu_clkctl_t CLK_CTL,
    output mdcu_pkg::mdcu_trace_t TRACE_PINS,
    output logic [7:0] FREEZE_ACTIVE,
    output logic SYSTICK_RUN
);
    logic [31:0] cfg_reg;
    logic [31:0] cfg_next;
    logic halt_s1_reg;
    logic halt_s2_reg;
    logic dbg_s1_reg;
    logic dbg_s2_reg;
    logic [2:0] lp_s1_reg;
    logic [2:0] lp_s2_reg;
    logic hit;
    logic word_ok;
    mdcu_pkg::mdcu_pmode_t pmode;
    mdcu_pkg::mdcu_clkctl_t clk_ctl_next;
    mdcu_pkg::mdcu_trace_t trace_next;

    // Address and size decode
    always_comb begin
        hit = 1'b0;
        word_ok = 1'b0;
        if (PPB_ADDR == mdcu_pkg::CFG_ADDR) begin
            hit = 1'b1; // [RULE_01]
            word_ok = (PPB_SIZE == mdcu_pkg::SIZE_WORD); // [RULE_02]
        end
    end

    // Next register value; no system reset term, any master may write
    always_comb begin
        cfg_next = cfg_reg;
        if (PPB_SEL && PPB_WRITE && hit && word_ok) begin
            cfg_next = PPB_WDATA & mdcu_pkg::CFG_WMASK; // [RULE_04] [RULE_05] [RULE_06]
        end
    end

    // Configuration register, cleared by power-on reset only
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_reg <= mdcu_pkg::CFG_RESET; // [RULE_03]
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Bus answer, one cycle after the request
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PPB_READY <= 1'b0;
            PPB_ERROR <= 1'b0;
            PPB_RDATA <= 32'h00000000;
        end else begin
            PPB_READY <= PPB_SEL;
            PPB_ERROR <= PPB_SEL && !(hit && word_ok); // [RULE_02]
            if (PPB_SEL && !PPB_WRITE && hit && word_ok) begin
                PPB_RDATA <= cfg_reg;
            end else begin
                PPB_RDATA <= 32'h00000000;
            end
        end
    end

    // Synchronisers for asynchronous status levels
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            halt_s1_reg <= 1'b0;
            halt_s2_reg <= 1'b0;
            dbg_s1_reg <= 1'b0;
            dbg_s2_reg <= 1'b0;
            lp_s1_reg <= 3'h0;
            lp_s2_reg <= 3'h0;
        end else begin
            halt_s1_reg <= CORE_HALTED;
            halt_s2_reg <= halt_s1_reg;
            dbg_s1_reg <= DEBUG_SESSION;
            dbg_s2_reg <= dbg_s1_reg;
            lp_s1_reg <= {LP_STANDBY, LP_STOP, LP_SLEEP};
            lp_s2_reg <= lp_s1_reg;
        end
    end

    // Low-power mode priority: standby over stop over sleep
    always_comb begin
        if (lp_s2_reg[2]) begin
            pmode = mdcu_pkg::MDCU_STANDBY;
        end else if (lp_s2_reg[1]) begin
            pmode = mdcu_pkg::MDCU_STOP;
        end else if (lp_s2_reg[0]) begin
            pmode = mdcu_pkg::MDCU_SLEEP;
        end else begin
            pmode = mdcu_pkg::MDCU_RUN;
        end
    end

    mdcu_clk_steer u_steer (
        .keep_sleep(cfg_reg[mdcu_pkg::SLEEP_BIT]),
        .keep_stop(cfg_reg[mdcu_pkg::STOP_BIT]),
        .keep_standby(cfg_reg[mdcu_pkg::STANDBY_BIT]),
        .debug_active(dbg_s2_reg),
        .pmode(pmode),
        .ctl(clk_ctl_next)
    );

    mdcu_trace_map u_trace (
        .enable(cfg_reg[mdcu_pkg::TRACE_EN_BIT]),
        .mode(cfg_reg[mdcu_pkg::TRACE_MODE_LO +: 2]),
        .assign_out(trace_next)
    );

    // Registered level outputs, effective the cycle after a write
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            DEBUG_SLEEP_KEEP_BUS_CLOCK <= 1'b0;
            DEBUG_STOP_KEEP_CLOCKS <= 1'b0;
            DEBUG_STANDBY_KEEP_CLOCKS <= 1'b0;
            TRACE_IO_ENABLE <= 1'b0;
            TRACE_MODE_SEL <= 2'h0;
        end else begin
            DEBUG_SLEEP_KEEP_BUS_CLOCK <= cfg_next[mdcu_pkg::SLEEP_BIT]; // [RULE_21]
            DEBUG_STOP_KEEP_CLOCKS <= cfg_next[mdcu_pkg::STOP_BIT];
            DEBUG_STANDBY_KEEP_CLOCKS <= cfg_next[mdcu_pkg::STANDBY_BIT];
            TRACE_IO_ENABLE <= cfg_next[mdcu_pkg::TRACE_EN_BIT];
            TRACE_MODE_SEL <= cfg_next[mdcu_pkg::TRACE_MODE_LO +: 2];
        end
    end

    // Registered steering to clock, power and pin controllers
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CLK_CTL <= '0;
            TRACE_PINS <= '0;
        end else begin
            CLK_CTL <= clk_ctl_next; // [RULE_09] [RULE_10] [RULE_11] [RULE_12]
            TRACE_PINS <= trace_next; // [RULE_07] [RULE_08]
        end
    end

    // Freeze requests gated by halt; system tick is never frozen
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            FREEZE_ACTIVE <= 8'h00;
            SYSTICK_RUN <= 1'b1;
        end else begin
            FREEZE_ACTIVE <= FREEZE_SELECT & {mdcu_pkg::FRZ_W{halt_s2_reg}}; // [RULE_19] [RULE_20]
            SYSTICK_RUN <= 1'b1; // [RULE_16]
        end
    end

    // Unused system reset level: the register ignores it by design
    logic sys_rst_unused;
    assign sys_rst_unused = SYS_RSTN;
endmodule : mdcu_top

// ### verilog/mdcu_trace_map.sv
`timescale 1ns/1ps
module mdcu_trace_map (
    // Configuration
    input wire logic enable,
    input wire logic [1:0] mode,
    // Assignment
    output mdcu_pkg::mdcu_trace_t assign_out
);
    // Decode trace pin assignment
    always_comb begin
        assign_out = '0;
        if (enable) begin
            case (mode)
                mdcu_pkg::TMODE_ASYNC: assign_out.swo_assigned = 1'b1; // [RULE_08]
                mdcu_pkg::TMODE_SYNC1: begin
                    assign_out.clk_assigned = 1'b1;
                    assign_out.lanes_assigned = 4'h1;
                end
                mdcu_pkg::TMODE_SYNC2: begin
                    assign_out.clk_assigned = 1'b1;
                    assign_out.lanes_assigned = 4'h3;
                end
                default: begin
                    assign_out.clk_assigned = 1'b1;
                    assign_out.lanes_assigned = 4'hf;
                end
            endcase
        end
    end // Disabled leaves nothing assigned [RULE_07]
endmodule : mdcu_trace_map
